// ### verilog/exec_unit.sv
`timescale 1ns/1ps
// one instruction per valid strobe; results appear on registered outputs next edge
module exec_unit (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // instruction from decoder
  input wire logic op_valid_in,
  input wire logic [2:0] op_in,
  input wire logic [4:0] file_addr_in,
  input wire logic dest_in,
  input wire logic [7:0] literal_in,
  input wire logic [2:0] dir_sel_in,
  // file register read data (addressed register)
  input wire logic [7:0] file_data_in,
  // file register write back
  output logic file_wr_out,
  output logic [4:0] file_wr_addr_out,
  output logic [7:0] file_wr_data_out,
  // architectural state
  output logic [7:0] acc_out,
  output logic carry_out,
  output logic zero_out,
  output logic [7:0] dir_a_out,
  output logic [7:0] dir_b_out,
  // bad direction operand seen
  output logic dir_error_out
);
  // decode helpers; is_dir_load and uses_dest each feed two strobes, the rest one strobe or mux each
  function automatic logic uses_dest(input logic [2:0] op);
    uses_dest = (op == exec_pkg::OP_ROTATE_RIGHT_CARRY) ||
                (op == exec_pkg::OP_NIBBLE_EXCHANGE) ||
                (op == exec_pkg::OP_REGISTER_XOR);
  endfunction : uses_dest

  function automatic logic is_xor_op(input logic [2:0] op);
    is_xor_op = (op == exec_pkg::OP_LITERAL_XOR) ||
                (op == exec_pkg::OP_REGISTER_XOR);
  endfunction : is_xor_op

  function automatic logic is_dir_load(input logic [2:0] op);
    is_dir_load = (op == exec_pkg::OP_PORT_DIRECTION_LOAD);
  endfunction : is_dir_load

  function automatic logic dir_operand_ok(input logic [2:0] sel);
    dir_operand_ok = (sel == exec_pkg::DIR_PORT_A) ||
                     (sel == exec_pkg::DIR_PORT_B);
  endfunction : dir_operand_ok

  function automatic logic [7:0] rotate_right(input logic [7:0] value, input logic carry);
    rotate_right = {carry, value[7:1]};
  endfunction : rotate_right

  function automatic logic [7:0] swap_nibbles(input logic [7:0] value);
    swap_nibbles = {value[3:0], value[7:4]};
  endfunction : swap_nibbles

  // decoded strobes, all but dir_ok qualified by the valid strobe
  logic acc_we;
  logic file_we;
  logic carry_we;
  logic zero_we;
  logic dir_we;
  logic dir_bad;
  logic dir_ok;

  // datapath
  logic [7:0] xor_operand;
  logic [7:0] xor_result;
  logic [7:0] result_d;
  logic carry_d;
  logic zero_d;
  logic [7:0] dir_q [exec_pkg::DIR_COUNT];

  assign dir_ok = dir_operand_ok(dir_sel_in);

  // where the result goes
  always_comb begin
    acc_we = 1'b0;
    file_we = 1'b0;
    if (op_valid_in) begin
      if (op_in == exec_pkg::OP_LITERAL_XOR) begin
        acc_we = 1'b1;
      end else if (uses_dest(op_in)) begin
        acc_we = !dest_in;
        file_we = dest_in;
      end
    end
  end

  // flag and direction latch strobes; swap enables none of them
  always_comb begin
    carry_we = 1'b0;
    zero_we = 1'b0;
    dir_we = 1'b0;
    dir_bad = 1'b0;
    if (op_valid_in) begin
      carry_we = (op_in == exec_pkg::OP_ROTATE_RIGHT_CARRY);
      zero_we = is_xor_op(op_in);
      dir_we = is_dir_load(op_in) && dir_ok;
      dir_bad = is_dir_load(op_in) && !dir_ok;
    end
  end

  // the literal only ever meets the accumulator; the other xor takes the file register
  always_comb begin
    if (op_in == exec_pkg::OP_LITERAL_XOR) begin
      xor_operand = literal_in;
    end else begin
      xor_operand = file_data_in;
    end
  end

  // one xor slice per bit
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_xor
      assign xor_result[b] = acc_out[b] ^ xor_operand[b];
    end
  endgenerate

  always_comb begin
    result_d = 8'h00;
    carry_d = carry_out;
    case (op_in)
      exec_pkg::OP_ROTATE_RIGHT_CARRY: begin
        result_d = rotate_right(file_data_in, carry_out);
        carry_d = file_data_in[0];
      end
      exec_pkg::OP_NIBBLE_EXCHANGE: begin
        result_d = swap_nibbles(file_data_in);
      end
      exec_pkg::OP_LITERAL_XOR: begin
        result_d = xor_result;
      end
      exec_pkg::OP_REGISTER_XOR: begin
        result_d = xor_result;
      end
      default: begin
        result_d = 8'h00;
      end
    endcase
  end

  // zero is judged on the full 8-bit result
  assign zero_d = (result_d == 8'h00);

  // accumulator
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      acc_out <= exec_pkg::ACC_RESET;
    end else if (acc_we) begin
      acc_out <= result_d;
    end
  end

  // file register write back; the register file sees the write one edge after the op
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      file_wr_out <= 1'b0;
    end else begin
      file_wr_out <= file_we;
    end
  end

  // address and data follow every cycle and only count while the strobe is high
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      file_wr_addr_out <= 5'h00;
    end else begin
      file_wr_addr_out <= file_addr_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      file_wr_data_out <= 8'h00;
    end else begin
      file_wr_data_out <= result_d;
    end
  end

  // status flags: swap and direction load touch neither
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      carry_out <= exec_pkg::CARRY_RESET;
    end else if (carry_we) begin
      carry_out <= carry_d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      zero_out <= exec_pkg::ZERO_RESET;
    end else if (zero_we) begin
      zero_out <= zero_d;
    end
  end

  // operands other than 6 or 7 are dropped and flagged for one cycle;
  // a silent drop would hide a decoder fault
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      dir_error_out <= 1'b0;
    end else begin
      dir_error_out <= dir_bad;
    end
  end

  direction_bank #(
    .COUNT(exec_pkg::DIR_COUNT)
  ) u_dir (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(dir_we),
    .wr_sel_in(dir_sel_in[0]),
    .wr_data_in(acc_out),
    .dir_out(dir_q)
  );

  // latch 6 sits in slot 0, latch 7 in slot 1
  assign dir_a_out = dir_q[0];
  assign dir_b_out = dir_q[1];
endmodule : exec_unit

// ### verilog/exec_pkg.sv
// Functional notes
// - rotate right through carry: old carry into bit 7, bit 0 to carry; carry only
// - rotate, swap, register xor: destination 0 writes accumulator, 1 writes file register
// - swap exchanges nibbles of file register; no status flag changes
// - literal xor: accumulator xor 8-bit immediate into accumulator; zero flag only
// - register xor: accumulator xor file register to destination; zero flag only
// - direction load copies accumulator into direction register 6 or 7; no flags
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [2:0] DIR_PORT_A = 3'h6;
  localparam logic [2:0] DIR_PORT_B = 3'h7;
  localparam int DIR_COUNT = 2;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ROTATE_RIGHT_CARRY = 3'b001,
    OP_NIBBLE_EXCHANGE = 3'b010,
    OP_LITERAL_XOR = 3'b011,
    OP_REGISTER_XOR = 3'b100,
    OP_PORT_DIRECTION_LOAD = 3'b101
  } op_t;
endpackage : exec_pkg

// ### verilog/direction_bank.sv
`timescale 1ns/1ps
// holds the port direction latches; read data registered
module direction_bank #(
  parameter int COUNT = exec_pkg::DIR_COUNT
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // write side
  input wire logic wr_en_in,
  input wire logic [0:0] wr_sel_in,
  input wire logic [7:0] wr_data_in,
  // registered contents
  output logic [7:0] dir_out [COUNT]
);
  genvar i;
  generate
    for (i = 0; i < COUNT; i++) begin : g_dir
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          dir_out[i] <= exec_pkg::DIR_RESET;
        end else if (wr_en_in && (wr_sel_in == 1'(i))) begin
          dir_out[i] <= wr_data_in;
        end
      end
    end
  endgenerate
endmodule : direction_bank

// ### verification/exec_monitor.sv
`timescale 1ns/1ps
module exec_monitor (
  input wire logic clock_in, rst_in, op_valid_in, dest_in, file_wr_out, carry_out, zero_out,
  input wire logic dir_error_out,
  input wire logic [2:0] op_in, dir_sel_in,
  input wire logic [4:0] file_addr_in, file_wr_addr_out,
  input wire logic [7:0] literal_in, file_data_in, file_wr_data_out, acc_out, dir_a_out,
  input wire logic [7:0] dir_b_out
);
  wire logic [2:0] opv = op_valid_in ? op_in : 3'h0;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  rotate_carry_a: assert property (opv == 3'h1 && !dest_in |=>
    $stable(zero_out) && carry_out == $past(file_data_in[0]) &&
    acc_out == {$past(carry_out), $past(file_data_in[7:1])})
    else $error("rotate");
  dest_select_a: assert property (opv inside {3'h1, 3'h2, 3'h4} |=>
    file_wr_out == $past(dest_in) && file_wr_addr_out == $past(file_addr_in)) else $error("dest");
  nibble_swap_a: assert property (opv == 3'h2 && dest_in |=> $stable(zero_out) &&
    file_wr_data_out == {$past(file_data_in[3:0]), $past(file_data_in[7:4])}) else $error("swap");
  literal_xor_a: assert property (opv == 3'h3 |=> $stable(carry_out) &&
    acc_out == ($past(acc_out) ^ $past(literal_in))) else $error("lxor");
  register_xor_a: assert property (opv == 3'h4 && dest_in |=> $stable(acc_out) &&
    file_wr_data_out == ($past(acc_out) ^ $past(file_data_in))) else $error("rxor");
  dir_load_a: assert property (opv == 3'h5 && dir_sel_in == 3'h6 |=> $stable(zero_out) &&
    dir_a_out == $past(acc_out)) else $error("dir");
  dir_load_b_a: assert property (opv == 3'h5 && dir_sel_in == 3'h7 |=>
    $stable(carry_out) && dir_b_out == $past(acc_out)) else $error("dir b");
  dir_reject_a: assert property (opv == 3'h5 && !(dir_sel_in inside {3'h6, 3'h7}) |=>
    dir_error_out && $stable(dir_a_out) && $stable(dir_b_out)) else $error("dir bad");
  xor_zero_a: assert property (opv inside {3'h3, 3'h4} && !dest_in |=>
    zero_out == !acc_out) else $error("zero");
endmodule : exec_monitor

bind exec_unit exec_monitor u_mon (.*);

// ### verification/file_regs.sv
`timescale 1ns/1ps
// port names mirror the unit's so the bench can connect by name
module file_regs (
  input wire logic clock_in, file_wr_out,
  input wire logic [4:0] file_addr_in, file_wr_addr_out,
  input wire logic [7:0] file_wr_data_out,
  output logic [7:0] file_data_in
);
  logic [7:0] mem_q [32];
  initial foreach (mem_q[i]) mem_q[i] = 8'(i * 37 + 5);
  always @(posedge clock_in) if (file_wr_out) mem_q[file_wr_addr_out] <= file_wr_data_out;
  // the write lands one edge after its op, so hand it to a reader of that register meanwhile
  assign file_data_in = (file_wr_out && file_wr_addr_out == file_addr_in) ?
                        file_wr_data_out : mem_q[file_addr_in];
endmodule : file_regs

// ### verification/tb_rotate_swap_xor_port_direction_load_op_exec.sv
`timescale 1ns/1ps
module tb_rotate_swap_xor_port_direction_load_op_exec;
  logic clock_in = 0, rst_in = 1, op_valid_in = 0, dest_in = 0;
  logic [2:0] op_in = 0, dir_sel_in = 0;
  logic [4:0] file_addr_in = 0;
  logic [7:0] literal_in = 0;
  wire logic [7:0] file_data_in, file_wr_data_out, acc_out, dir_a_out, dir_b_out;
  wire logic [4:0] file_wr_addr_out;
  wire logic file_wr_out, carry_out, zero_out, dir_error_out;
  int miscompares, checks_done, acc, c, z, da = 255, db = 255, r, fd, e, fw, wa;
  int m [32];
  always #10 clock_in = ~clock_in;
  exec_unit u_dut (.*);
  file_regs u_regs (.*);
  task automatic chk(input logic [31:0] seen, input int exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d wrong %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    foreach (m[i]) m[i] = (i * 37 + 5) % 256;
    void'($urandom(90));
    repeat (20) @(negedge clock_in);
    rst_in = 0;
    repeat (400) begin
      chk({acc_out, dir_a_out, dir_b_out}, acc << 16 | da << 8 | db, "regs");
      chk({carry_out, zero_out, file_wr_out, dir_error_out}, c * 8 + z * 4 + fw * 2 + e, "flags");
      if (fw) chk(file_wr_data_out, r, "wdata");
      if (fw) chk(file_wr_addr_out, wa, "waddr");
      {op_valid_in, op_in, dest_in, dir_sel_in, file_addr_in, literal_in} = 21'($urandom);
      wa = file_addr_in;
      fd = m[file_addr_in];
      r = -1;
      e = 0;
      if (op_valid_in) case (op_in)
        1: begin r = c * 128 + fd / 2; c = fd % 2; end
        2: r = fd % 16 * 16 + fd / 16;
        3: begin acc ^= literal_in; z = acc == 0; end
        4: begin r = acc ^ fd; z = r == 0; end
        5: if (dir_sel_in == 6) da = acc; else if (dir_sel_in == 7) db = acc; else e = 1;
      endcase
      fw = r >= 0 && dest_in;
      if (fw) m[file_addr_in] = r; else if (r >= 0) acc = r;
      @(negedge clock_in);
    end
    $display("random op run done");
    tally_and_finish();
  end
endmodule : tb_rotate_swap_xor_port_direction_load_op_exec
